//--- cfm_mixer.sv
// Crossfade blend mixer: two multichannel ports into one, per sample.
// Summary of operation
// - Two ports of sixteen channels mix channel by channel into one.
// - Selector mode targets the on ratio when on, the off ratio when off.
// - Selector mode weights port B by one minus the applied A portion.
// - A glide of one makes the applied gain jump to target in one sample.
// - Larger glide values reach the target faster, tiny ones very slowly.
// - Linear variant steps the gain by a constant amount per sample.
// - Low-pass variant steps by a fraction of the remaining distance.
// - Summer mode outputs A times its gain plus B times its own gain.
// - Summer gains glide whenever either setting changes.
// - Bypass passes port A unchanged and ignores port B in both modes.
// Assumes in_valid pulses once per sample; registers over Avalon-MM.
`timescale 1ns/1ns
module cfm_mixer
  import cfm_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // Avalon-MM slave
  input  wire logic [AW-1:0]     avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Input stream
  input  wire logic              in_valid,
  input  wire cfm_frame_t        in_a,
  input  wire cfm_frame_t        in_b,
  // Output stream
  output logic                   out_valid,
  output cfm_frame_t             out_data
);

  // Software registers
  cfm_ctrl_t                 ctrl;
  logic [RATIO_W-1:0]        on_ratio;
  logic [RATIO_W-1:0]        off_ratio;
  logic [RATIO_W-1:0]        glide;
  logic signed [DB_W-1:0]    gain_a_db;
  logic signed [DB_W-1:0]    gain_b_db;
  cfm_ctrl_t                 next_ctrl;
  logic [RATIO_W-1:0]        next_on_ratio;
  logic [RATIO_W-1:0]        next_off_ratio;
  logic [RATIO_W-1:0]        next_glide;
  logic signed [DB_W-1:0]    next_gain_a_db;
  logic signed [DB_W-1:0]    next_gain_b_db;
  logic [31:0]               next_readdata;
  logic                      next_waitrequest;

  // Gain path
  logic [GAIN_W-1:0]         lin_a;
  logic [GAIN_W-1:0]         lin_b;
  logic [GAIN_W-1:0]         target_a;
  logic [GAIN_W-1:0]         applied_a;
  logic [GAIN_W-1:0]         applied_b;
  logic [GAIN_W-1:0]         weight_b;

  // Output stream next values
  logic                      next_out_valid;
  cfm_frame_t                next_out_data;

  logic                      access;
  logic [31:0]               wr_word;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  // Ratios and glide stay within zero to one
  function automatic logic [RATIO_W-1:0] clamp_ratio(input logic [31:0] w);
    logic [RATIO_W-1:0] r;
    if (w > 32'(RATIO_ONE))
      r = RATIO_ONE;
    else
      r = w[RATIO_W-1:0];
    return r;
  endfunction

  // One channel: weighted sum, rescaled and saturated
  function automatic cfm_sample_t mix_ch(input cfm_sample_t       a,
                                         input cfm_sample_t       b,
                                         input logic [GAIN_W-1:0] ga,
                                         input logic [GAIN_W-1:0] gb);
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] hi;
    logic signed [ACC_W-1:0] lo;
    cfm_sample_t             r;
    hi  = ACC_W'({1'b0, {(SW-1){1'b1}}});
    lo  = -hi - ACC_W'(1);
    acc = ACC_W'(a) * $signed(ACC_W'({1'b0, ga}))
        + ACC_W'(b) * $signed(ACC_W'({1'b0, gb}));
    acc = acc >>> FRAC;
    if (acc > hi)
      r = hi[SW-1:0];
    else if (acc < lo)
      r = lo[SW-1:0];
    else
      r = acc[SW-1:0];
    return r;
  endfunction

  // Register bus: one wait cycle, answer on the second edge
  always_comb
  begin
    access           = (avs_read | avs_write) & avs_waitrequest;
    next_waitrequest = ~access;
    next_readdata    = avs_readdata;
    next_ctrl        = ctrl;
    next_on_ratio    = on_ratio;
    next_off_ratio   = off_ratio;
    next_glide       = glide;
    next_gain_a_db   = gain_a_db;
    next_gain_b_db   = gain_b_db;
    wr_word          = RD_ZERO;
    // Write lands at the answer edge, while the master still holds it
    if (avs_write && !avs_waitrequest)
    begin
      unique case (avs_address)
        OFS_CTRL:
        begin
          wr_word   = be_merge(32'(ctrl), avs_writedata, avs_byteenable);
          next_ctrl = cfm_ctrl_t'(wr_word[3:0]);
        end
        OFS_ON_RATIO:
        begin
          wr_word       = be_merge(32'(on_ratio), avs_writedata,
                                   avs_byteenable);
          next_on_ratio = clamp_ratio(wr_word);
        end
        OFS_OFF_RATIO:
        begin
          wr_word        = be_merge(32'(off_ratio), avs_writedata,
                                    avs_byteenable);
          next_off_ratio = clamp_ratio(wr_word);
        end
        OFS_GLIDE:
        begin
          wr_word    = be_merge(32'(glide), avs_writedata, avs_byteenable);
          next_glide = clamp_ratio(wr_word);
        end
        OFS_GAIN_A_DB:
        begin
          wr_word        = be_merge(32'(gain_a_db), avs_writedata,
                                    avs_byteenable);
          next_gain_a_db = wr_word[DB_W-1:0];
        end
        OFS_GAIN_B_DB:
        begin
          wr_word        = be_merge(32'(gain_b_db), avs_writedata,
                                    avs_byteenable);
          next_gain_b_db = wr_word[DB_W-1:0];
        end
        default:
          wr_word = RD_ZERO;
      endcase
    end
    if (access && avs_read)
    begin
      unique case (avs_address)
        OFS_CTRL:      next_readdata = 32'(ctrl);
        OFS_ON_RATIO:  next_readdata = 32'(on_ratio);
        OFS_OFF_RATIO: next_readdata = 32'(off_ratio);
        OFS_GLIDE:     next_readdata = 32'(glide);
        OFS_GAIN_A_DB: next_readdata = 32'(gain_a_db);
        OFS_GAIN_B_DB: next_readdata = 32'(gain_b_db);
        OFS_APPLIED_A: next_readdata = 32'(applied_a);
        OFS_APPLIED_B: next_readdata = 32'(weight_b);
        default:       next_readdata = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrl            <= cfm_ctrl_t'(RST_CTRL);
      on_ratio        <= RST_ON_RATIO;
      off_ratio       <= RST_OFF_RATIO;
      glide           <= RST_GLIDE;
      gain_a_db       <= RST_GAIN_DB;
      gain_b_db       <= RST_GAIN_DB;
      avs_readdata    <= RD_ZERO;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      ctrl            <= next_ctrl;
      on_ratio        <= next_on_ratio;
      off_ratio       <= next_off_ratio;
      glide           <= next_glide;
      gain_a_db       <= next_gain_a_db;
      gain_b_db       <= next_gain_b_db;
      avs_readdata    <= next_readdata;
      avs_waitrequest <= next_waitrequest;
    end
  end

  // Decibel settings to linear multipliers
  cfm_db_to_lin u_lin_a (
    .sys_clk (sys_clk),
    .reset   (reset),
    .db      (gain_a_db),
    .lin     (lin_a)
  );

  cfm_db_to_lin u_lin_b (
    .sys_clk (sys_clk),
    .reset   (reset),
    .db      (gain_b_db),
    .lin     (lin_b)
  );

  // Port A target: selector ratio or summer gain
  always_comb
  begin
    if (ctrl.summer)
      target_a = lin_a;
    else if (ctrl.sel_on)
      target_a = GAIN_W'(on_ratio);
    else
      target_a = GAIN_W'(off_ratio);
  end

  cfm_glide u_glide_a (
    .sys_clk (sys_clk),
    .reset   (reset),
    .step_en (in_valid),
    .lpf     (ctrl.lpf),
    .glide   (glide),
    .target  (target_a),
    .gain    (applied_a)
  );

  // Port B gain glides only in summer mode
  cfm_glide u_glide_b (
    .sys_clk (sys_clk),
    .reset   (reset),
    .step_en (in_valid & ctrl.summer),
    .lpf     (ctrl.lpf),
    .glide   (glide),
    .target  (lin_b),
    .gain    (applied_b)
  );

  // Port B weight
  always_comb
  begin
    if (ctrl.summer)
      weight_b = applied_b;
    else if (applied_a >= GAIN_ONE)
      weight_b = '0;
    else
      weight_b = GAIN_ONE - applied_a;
  end

  // Per-sample mix, each channel pair on its own
  always_comb
  begin
    next_out_valid = in_valid;
    next_out_data  = out_data;
    if (in_valid)
    begin
      for (int ch = 0; ch < NCH; ch++)
      begin
        if (ctrl.bypass)
          next_out_data[ch] = in_a[ch];
        else
          next_out_data[ch] = mix_ch(in_a[ch], in_b[ch],
                                     applied_a, weight_b);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end

endmodule

//--- cfm_pkg.sv
// Shared constants, types and helpers for the crossfade blend mixer.
// Assumes one 125 MHz clock and a synchronous active-high reset.
package cfm_pkg;

  // Stream shape: widest configuration, 32 in, 16 out
  localparam int NCH     = 16;
  localparam int SW      = 24;

  // Gain and ratio formats, unsigned with 16 fraction bits
  localparam int FRAC    = 16;
  localparam int GAIN_W  = 18;
  localparam int RATIO_W = 17;
  localparam int DB_W    = 9;
  localparam int ACC_W   = SW + GAIN_W + 2;

  localparam logic [RATIO_W-1:0] RATIO_ONE = 17'h1_0000;
  localparam logic [GAIN_W-1:0]  GAIN_ONE  = 18'h1_0000;
  localparam logic [GAIN_W-1:0]  GAIN_MAX  = 18'h3_FFFF;

  // Decibel range and conversion steps
  localparam logic signed [DB_W-1:0] DB_MIN  = -9'sd160;
  localparam logic signed [DB_W-1:0] DB_MAX  = 9'sd12;
  localparam logic [7:0]             DB_BIAS = 8'h00A2;
  localparam int                     DB_STEP = 6;
  localparam int                     DB_SHR  = 27;

  // Avalon register map, byte addresses
  localparam int AW = 5;
  localparam logic [AW-1:0] OFS_CTRL      = 5'h00;
  localparam logic [AW-1:0] OFS_ON_RATIO  = 5'h04;
  localparam logic [AW-1:0] OFS_OFF_RATIO = 5'h08;
  localparam logic [AW-1:0] OFS_GLIDE     = 5'h0C;
  localparam logic [AW-1:0] OFS_GAIN_A_DB = 5'h10;
  localparam logic [AW-1:0] OFS_GAIN_B_DB = 5'h14;
  localparam logic [AW-1:0] OFS_APPLIED_A = 5'h18;
  localparam logic [AW-1:0] OFS_APPLIED_B = 5'h1C;

  // Reset values
  localparam logic [3:0]             RST_CTRL      = 4'h0;
  localparam logic [RATIO_W-1:0]     RST_ON_RATIO  = 17'h1_0000;
  localparam logic [RATIO_W-1:0]     RST_OFF_RATIO = 17'h0_0000;
  localparam logic [RATIO_W-1:0]     RST_GLIDE     = 17'h1_0000;
  localparam logic signed [DB_W-1:0] RST_GAIN_DB   = 9'h000;
  localparam logic [31:0]            RD_ZERO       = 32'h0000_0000;

  typedef logic signed [SW-1:0] cfm_sample_t;
  typedef cfm_sample_t [NCH-1:0] cfm_frame_t;

  // Control word, bit 0 upward: summer, lpf, sel_on, bypass
  typedef struct packed {
    logic bypass;
    logic sel_on;
    logic lpf;
    logic summer;
  } cfm_ctrl_t;

  // 10^(k/20) for k = 0..5 in gain format
  function automatic logic [GAIN_W-1:0] db_frac(input logic [2:0] k);
    logic [GAIN_W-1:0] v;
    v = GAIN_ONE;
    unique case (k)
      3'h0:    v = 18'h1_0000;
      3'h1:    v = 18'h1_1F3D;
      3'h2:    v = 18'h1_4246;
      3'h3:    v = 18'h1_6998;
      3'h4:    v = 18'h1_95B7;
      3'h5:    v = 18'h1_C739;
      default: v = GAIN_ONE;
    endcase
    return v;
  endfunction

endpackage

//--- cfm_db_to_lin.sv
// Decibel gain setting to linear multiplier, registered output.
// Assumes the setting is a signed integer count of decibels.
`timescale 1ns/1ns
module cfm_db_to_lin
  import cfm_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // Setting in, multiplier out
  input  wire logic signed [DB_W-1:0] db,
  output logic         [GAIN_W-1:0]   lin
);

  logic signed [DB_W-1:0] db_c;
  logic        [7:0]      idx;
  logic        [4:0]      oct;
  logic        [2:0]      rem;
  logic        [47:0]     wide;
  logic        [GAIN_W-1:0] next_lin;

  always_comb
  begin
    db_c = db;
    if (db < DB_MIN)
      db_c = DB_MIN;
    else if (db > DB_MAX)
      db_c = DB_MAX;
    idx  = 8'(db_c) + DB_BIAS;
    oct  = 5'(idx / 8'(DB_STEP));
    rem  = 3'(idx % 8'(DB_STEP));
    // Six decibels taken as one octave
    wide = (48'(db_frac(rem)) << oct) >> DB_SHR;
    if (wide > 48'(GAIN_MAX))
      next_lin = GAIN_MAX;
    else
      next_lin = wide[GAIN_W-1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      lin <= GAIN_ONE;
    else
      lin <= next_lin;
  end

endmodule

//--- cfm_glide.sv
// Gain glider: moves an applied gain toward its target once per sample.
// Assumes step_en pulses once per sample period.
`timescale 1ns/1ns
module cfm_glide
  import cfm_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // Control
  input  wire logic               step_en,
  input  wire logic               lpf,
  input  wire logic [RATIO_W-1:0] glide,
  input  wire logic [GAIN_W-1:0]  target,
  // Applied gain
  output logic      [GAIN_W-1:0]  gain
);

  localparam int PW = GAIN_W + 1 + RATIO_W + 1;

  logic signed [GAIN_W:0]  diff;
  logic signed [GAIN_W:0]  gl_s;
  logic signed [PW-1:0]    prod;
  logic signed [PW-1:0]    stp;
  logic        [GAIN_W-1:0] next_gain;

  always_comb
  begin
    diff      = $signed({1'b0, target}) - $signed({1'b0, gain});
    gl_s      = $signed((GAIN_W+1)'(glide));
    prod      = PW'(diff) * PW'(gl_s);
    stp       = prod >>> FRAC;
    next_gain = gain;
    if (step_en)
    begin
      if (glide >= RATIO_ONE)
        next_gain = target;
      else if (glide == '0)
        next_gain = gain;
      else if (lpf)
      begin
        // Step shrinks with distance; never stalls short of target
        if (stp == '0 && diff != '0)
          stp = (diff < 0) ? -PW'(1) : PW'(1);
        next_gain = GAIN_W'(PW'({1'b0, gain}) + stp);
      end
      else if (diff > gl_s)
        next_gain = GAIN_W'(gain + GAIN_W'(glide));
      else if (diff < -gl_s)
        next_gain = GAIN_W'(gain - GAIN_W'(glide));
      else
        next_gain = target;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      gain <= GAIN_ONE;
    else
      gain <= next_gain;
  end

endmodule

//--- cfm_assertions.sv
// Port checker for cfm_mixer: bus answer timing, stream timing, mixing.
// Assumes a bind to cfm_mixer; the control word is shadowed from writes.
`timescale 1ns/1ns
module cfm_assertions
  import cfm_pkg::*;
(
  // Clock and reset
  input wire logic          sys_clk,
  input wire logic          reset,
  // Register bus
  input wire logic [AW-1:0] avs_address,
  input wire logic          avs_read,
  input wire logic          avs_write,
  input wire logic [31:0]   avs_writedata,
  input wire logic [31:0]   avs_readdata,
  input wire logic          avs_waitrequest,
  // Streams
  input wire logic          in_valid,
  input wire cfm_frame_t    in_a,
  input wire cfm_frame_t    in_b,
  input wire logic          out_valid,
  input wire cfm_frame_t    out_data
);
  cfm_ctrl_t ctrl;
  cfm_ctrl_t next_ctrl;
  logic      rd_done;

  assign rd_done = avs_read && !avs_waitrequest;

  // Shadow of the control word, taken at the write answer edge
  always_comb
  begin
    next_ctrl = ctrl;
    if (avs_write && !avs_waitrequest && avs_address == OFS_CTRL)
      next_ctrl = cfm_ctrl_t'(avs_writedata[3:0]);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ctrl <= cfm_ctrl_t'(RST_CTRL);
    else
      ctrl <= next_ctrl;
  end

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  out_follow_a: assert property (in_valid |=> out_valid)
    else $error("out_valid missing after a sample");
  out_only_a: assert property (!in_valid |=> !out_valid)
    else $error("out_valid without a sample");
  data_hold_a: assert property (!in_valid |=> $stable(out_data))
    else $error("out_data changed between samples");
  bus_answer_a: assert property
    ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  unmapped_zero_a: assert property
    (rd_done && avs_address[1:0] != 2'h0 |-> avs_readdata == RD_ZERO)
    else $error("unmapped read not zero");
  glide_clamp_a: assert property
    (rd_done && avs_address == OFS_GLIDE |-> avs_readdata <= 32'h0001_0000)
    else $error("glide above one");
  bypass_pass_a: assert property
    (in_valid && ctrl.bypass |=> out_data == $past(in_a))
    else $error("bypass output differs from port A");
  unity_mix_a: assert property
    (in_valid && !ctrl.bypass && !ctrl.summer && in_a == in_b
     |=> out_data == $past(in_a))
    else $error("selector weights do not sum to one");
endmodule

//--- cfm_src.sv
// Upstream sample source: one random frame pair per fire pulse.
// Assumes the bench raises fire for one cycle per wanted sample.
`timescale 1ns/1ns
module cfm_src
  import cfm_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Commands from the bench
  input  wire logic fire,
  input  wire logic twin,
  // Stream toward the mixer
  output logic      in_valid,
  output cfm_frame_t in_a,
  output cfm_frame_t in_b
);
  cfm_frame_t ra;

  // Data lines change every idle cycle; cleared while in reset
  always @(posedge sys_clk)
  begin
    in_valid <= fire && !reset;
    for (int c = 0; c < NCH; c++)
      ra[c] = SW'($urandom);
    in_a <= reset ? '0 : (fire ? ra : ~in_a);
    for (int c = 0; c < NCH; c++)
      ra[c] = twin ? ra[c] : SW'($urandom);
    in_b <= reset ? '0 : (fire ? ra : ~in_b);
  end
endmodule

//--- tb.sv
// Testbench for cfm_mixer: register map, selector, summer, glide, bypass.
// Assumes cfm_src upstream and cfm_assertions bound to the mixer.
`timescale 1ns/1ns
module tb
  import cfm_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              reset, fire, twin, lp, sm;
  logic              avs_read, avs_write, avs_waitrequest;
  logic              in_valid, out_valid;
  logic [AW-1:0]     avs_address;
  logic [31:0]       avs_writedata, avs_readdata;
  cfm_frame_t        in_a, in_b, out_data;
  int                miscompares, n_compared, gl;
  logic [3:0]        be = 4'hF;
  logic [GAIN_W-1:0] ga, gb, tga, tgb;
  logic [31:0]       rst_v [8] = '{32'(RST_CTRL), 32'(RST_ON_RATIO),
    32'(RST_OFF_RATIO), 32'(RST_GLIDE), {23'h0, RST_GAIN_DB},
    {23'h0, RST_GAIN_DB}, 32'(GAIN_ONE), RD_ZERO};
  logic [DB_W-1:0]   db_set [5] = '{9'h000, 9'h006, 9'h00C, 9'h160, 9'h014};
  logic [GAIN_W-1:0] db_lin [5] = '{18'h1_0000, 18'h2_0000, GAIN_MAX,
    18'h0_0000, GAIN_MAX};

  always #4 sys_clk = ~sys_clk;

  cfm_mixer dut (.sys_clk(sys_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .in_valid(in_valid), .in_a(in_a), .in_b(in_b),
    .out_valid(out_valid), .out_data(out_data));
  cfm_src src (.sys_clk(sys_clk), .reset(reset), .fire(fire), .twin(twin),
    .in_valid(in_valid), .in_a(in_a), .in_b(in_b));

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic hang(input int n);
    if (n >= 16)
    begin
      miscompares++;
      $display("Error timeout waiting for an answer");
      report_and_stop();
    end
  endtask

  task automatic chk_word(input logic [AW-1:0] ad, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error reg %h expected %h seen %h", ad, e, g);
    end
  endtask

  task automatic chk_smp(input int ch, input cfm_sample_t e, g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error channel %0d expected %h seen %h", ch, e, g);
    end
  endtask

  // Write when w is set, otherwise read and compare with d
  task automatic acc(input logic w, input logic [AW-1:0] ad,
                     input logic [31:0] d);
    int n;
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 16);
    hang(n);
    if (!w)
      chk_word(ad, d, avs_readdata);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  function automatic cfm_sample_t mix(input cfm_sample_t a, b,
                                      input logic [GAIN_W-1:0] x, y);
    longint s;
    s = (longint'(a) * longint'(x) + longint'(b) * longint'(y)) >>> 16;
    if (s > 64'sh0000_0000_007F_FFFF)
      s = 64'sh0000_0000_007F_FFFF;
    if (s < -64'sh0000_0000_0080_0000)
      s = -64'sh0000_0000_0080_0000;
    return SW'(s);
  endfunction

  function automatic logic [GAIN_W-1:0] step(input logic [GAIN_W-1:0] g, t);
    longint d;
    d = longint'(t) - longint'(g);
    if (gl >= 32'h0001_0000)
      return t;
    if (lp)
      d = (d * gl) >>> 16;
    else if (d > gl)
      d = gl;
    else if (d < -gl)
      d = -gl;
    if (d == 0 && t != g)
      d = (t > g) ? 1 : -1;
    return (gl == 0) ? g : GAIN_W'(longint'(g) + d);
  endfunction

  task automatic send(input logic chk, input logic tw, input logic byp);
    cfm_frame_t a, b;
    logic [GAIN_W-1:0] y;
    int n;
    twin <= tw;
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    @(posedge sys_clk);
    a = in_a;
    b = in_b;
    y = sm ? gb : GAIN_ONE - ga;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (out_valid !== 1'b1 && n < 16);
    hang(n);
    for (int c = 0; c < NCH; c++)
      if (chk)
        chk_smp(c, byp ? a[c] : mix(a[c], b[c], ga, y), out_data[c]);
    ga = step(ga, tga);
    gb = step(gb, tgb);
  endtask

  initial
  begin
    logic [RATIO_W-1:0] on, off;
    logic s;
    void'($urandom(32'hdb27d5e0));
    {miscompares, n_compared, lp, sm, fire, twin} = '0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    reset = 1'b1;
    gl = 32'h0001_0000;
    ga = GAIN_ONE;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++)
      acc(1'b0, AW'(i * 4), rst_v[i]);
    acc(1'b0, 5'h02, RD_ZERO);
    acc(1'b1, OFS_GLIDE, 32'h0001_FFFF);
    acc(1'b0, OFS_GLIDE, 32'h0001_0000);
    for (int i = 0; i < 6; i++)
    begin
      on = (i == 0) ? RATIO_ONE : RATIO_W'($urandom_range(32'h0001_0000));
      off = (i == 0) ? '0 : RATIO_W'($urandom_range(32'h0001_0000));
      s = (i == 0) ? 1'b1 : 1'($urandom);
      acc(1'b1, OFS_ON_RATIO, 32'(on));
      acc(1'b1, OFS_OFF_RATIO, 32'(off));
      acc(1'b1, OFS_CTRL, {29'h0, s, 2'h0});
      tga = s ? GAIN_W'(on) : GAIN_W'(off);
      send(1'b1, 1'b1, 1'b0);
      send(1'b1, 1'b0, 1'b0);
      acc(1'b0, OFS_APPLIED_A, 32'(ga));
      acc(1'b0, OFS_APPLIED_B, 32'(GAIN_ONE - ga));
    end
    acc(1'b1, OFS_CTRL, 32'h0000_000C);
    send(1'b1, 1'b0, 1'b1);
    acc(1'b1, OFS_CTRL, 32'h0000_0009);
    send(1'b1, 1'b0, 1'b1);
    acc(1'b1, OFS_CTRL, 32'h0000_0001);
    sm = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      acc(1'b1, OFS_GAIN_A_DB, {23'h0, db_set[i]});
      acc(1'b1, OFS_GAIN_B_DB, {23'h0, db_set[(i + 2) % 5]});
      tga = db_lin[i];
      tgb = db_lin[(i + 2) % 5];
      send(i > 0, 1'b0, 1'b0);
      send(1'b1, 1'b0, 1'b0);
      acc(1'b0, OFS_APPLIED_A, 32'(tga));
      acc(1'b0, OFS_APPLIED_B, 32'(tgb));
    end
    acc(1'b1, OFS_OFF_RATIO, RD_ZERO);
    acc(1'b1, OFS_CTRL, RD_ZERO);
    sm = 1'b0;
    tga = '0;
    send(1'b0, 1'b0, 1'b0);
    acc(1'b1, OFS_ON_RATIO, 32'h0001_0000);
    acc(1'b1, OFS_GLIDE, 32'h0000_0100);
    gl = 32'h0000_0100;
    acc(1'b1, OFS_CTRL, 32'h0000_0004);
    tga = GAIN_ONE;
    repeat (4) send(1'b1, 1'b0, 1'b0);
    acc(1'b0, OFS_APPLIED_A, 32'h0000_0400);
    acc(1'b1, OFS_GLIDE, RD_ZERO);
    gl = 0;
    repeat (2) send(1'b1, 1'b0, 1'b0);
    acc(1'b0, OFS_APPLIED_A, 32'h0000_0400);
    acc(1'b1, OFS_GLIDE, 32'h0000_8000);
    gl = 32'h0000_8000;
    lp = 1'b1;
    acc(1'b1, OFS_CTRL, 32'h0000_0006);
    repeat (4) send(1'b1, 1'b1, 1'b0);
    acc(1'b0, OFS_APPLIED_A, 32'(ga));
    // Single byte lane merges into the stored ratio
    be <= 4'h1;
    acc(1'b1, OFS_OFF_RATIO, 32'hFFFF_FF34);
    be <= 4'hF;
    acc(1'b0, OFS_OFF_RATIO, 32'h0000_0034);
    report_and_stop();
  end
endmodule

bind cfm_mixer cfm_assertions u_chk (.sys_clk(sys_clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .in_valid(in_valid), .in_a(in_a),
  .in_b(in_b), .out_valid(out_valid), .out_data(out_data));
